/* File: design/fpd_pkg.sv */
// package: constants and carriers for the floppy precomp and drive timing block
package fpd_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] FPD_CTRL_ADDR   = 8'h00;  // control latch
  localparam logic [7:0] FPD_STATUS_ADDR = 8'h04;  // status, writing 1 to bit 0 clears the write-protect bit
  localparam logic [7:0] FPD_PHASE_ADDR  = 8'h08;  // precomp phase length

  // control field positions
  localparam int FPD_C_EIGHT    = 0;  // drive-size select, 1 = 8 inch
  localparam int FPD_C_PRECOMP  = 1;  // precomp request, active low
  localparam int FPD_C_QSEEK    = 2;  // quick-seek enable
  localparam int FPD_C_WAIT_INSERT_ENABLE   = 3;  // wait-insert enable
  localparam int FPD_C_DOUBLE_DENSITY_ENABLE     = 4;  // double density enable

  // reset values
  localparam logic [4:0] FPD_CTRL_RST  = 5'h02;  // precomp request idle high
  localparam logic [7:0] FPD_PHASE_RST = 8'h0c;  // cycles per precomp phase

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int FPD_CLK_MHZ       = 100;
  localparam int FPD_SETTLE_MS     = 50;
  localparam int FPD_MOTOR_S       = 20;
  localparam int FPD_SETTLE_CYC    = FPD_SETTLE_MS * 1000 * FPD_CLK_MHZ;  // no 32-bit overflow
  localparam longint FPD_MOTOR_CYC = 64'(FPD_MOTOR_S) * 1000000 * FPD_CLK_MHZ;
  localparam int FPD_DIV_1MHZ      = FPD_CLK_MHZ / 2;  // half period for 1 MHz
  localparam int FPD_DIV_2MHZ      = FPD_CLK_MHZ / 4;  // half period for 2 MHz

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       write_gate;
    logic       head_load_cmd;
    logic       inner_track_flag;
    logic       early;
    logic       late;
    logic       write_bit;    // one-cycle pulse, a bit to write
    logic       step;         // one-cycle pulse, head move
    logic       step_in;
    logic       side;
    logic       seeking;
    logic       access;       // a disk command is running
    logic       write_cmd;    // pulse, a write command starts
    logic       data_reg_acc; // access to the data register
    logic       xfer_req;     // data_transfer_req from the controller
  } fpd_ctl_s;

  typedef struct packed {
    logic ready;
    logic double_sided_flag;
    logic write_protected_in;
    logic index;
    logic track0;
  } fpd_drv_s;

  typedef enum logic [1:0] {FPD_IDLE, FPD_RIPPLE} fpd_pc_e;

endpackage : fpd_pkg

/* File: design/fpd_top.sv */
// floppy precomp, data recovery control and drive timing with an APB register slave
//
// Operation
// R1: recovery enabled only while write gate and recovery-fault input both low
// R2: read clock divisor is 16 with double density enable high, else 8
// R3: precompensate double-density writes for 80-track media
// R4: no select leaves at phase 2, late at phase 3, early at phase 1
// R5: a write bit latches the strobe and starts a four-phase low ripple
// R6: phase 4 low clears the strobe for the next write bit
// R7: precompensate only with double density enable one and inner-track high
// R8: controller track flag beyond 43 forces inner-track high
// R9: software drives precomp request low to precompensate every track
// R10: head-load raises head load output and holds settled low about 50 ms
// R11: controller clock 1 MHz for 5.25 inch, 2 MHz for 8 inch
// R12: quick-seek raises clock to 2 MHz during seeks, back after seek ends
// R13: 8 inch head-load output is inverted toward the cable
// R14: 8 inch inputs pass only with size select high; ready, two-sided inverted
// R15: 5.25 inch inputs pass only with size select low
// R16: 5.25 inch motor on during access and about 20 s after
// R17: direction high stepping in, low stepping out
// R18: surface select high for side 1, low for side 0
// R19: each head-move pulse moves one track
// R20: write protect refuses write commands and sets the status bit
// R21: wait-insert enable holds bus ready low on data register access
// R22: write pulses leave precompensated with clock bits interleaved
// R23: precomp phase length is a programmable count of pclk cycles
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module fpd_top
#(
  parameter int SETTLE_CYC = fpd_pkg::FPD_SETTLE_CYC,
  parameter longint MOTOR_CYC = fpd_pkg::FPD_MOTOR_CYC
)
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // controller side
  input  wire fpd_pkg::fpd_ctl_s ctl,
  input  wire logic              recovery_enable_fault,
  input  wire logic              raw_flux_stream,
  output logic                   recovery_on,
  output logic [4:0]             rclk_div,
  output logic                   ctrl_clk,
  output logic                   head_settled,
  output logic                   write_refused,
  output logic                   bus_ready,
  // drive cables
  input  wire fpd_pkg::fpd_drv_s drv8,
  input  wire fpd_pkg::fpd_drv_s drv5,
  output fpd_pkg::fpd_drv_s      drv_in,
  output logic                   write_pulse_out,
  output logic                   head_load_8_n,
  output logic                   head_load_5,
  output logic                   motor_on_5,
  output logic                   step_out,
  output logic                   dir_out,
  output logic                   surface_select
);
  import fpd_pkg::*;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [4:0]  ctrl_reg;
  logic [4:0]  next_ctrl_reg;
  logic [7:0]  phase_len;
  logic [7:0]  next_phase_len;
  logic        wp_sticky;
  logic        next_wp_sticky;
  logic        wr_en;
  logic        addr_ok;
  logic        inner_trk;
  logic        pc_active;
  logic        strobe;

  assign wr_en   = psel && penable && pwrite;
  assign addr_ok = (paddr == FPD_CTRL_ADDR) || (paddr == FPD_STATUS_ADDR)
                   || (paddr == FPD_PHASE_ADDR);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // register next values; status write-one clears, a new refusal wins
  always_comb
  begin
    next_ctrl_reg  = ctrl_reg;
    next_phase_len = phase_len;
    next_wp_sticky = wp_sticky;
    if (wr_en && paddr == FPD_CTRL_ADDR)
      next_ctrl_reg = pwdata[4:0];
    else if (wr_en && paddr == FPD_PHASE_ADDR)
      next_phase_len = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];  // [R23]
    else if (wr_en && paddr == FPD_STATUS_ADDR && pwdata[0])
      next_wp_sticky = 1'b0;
    if (write_refused)
      next_wp_sticky = 1'b1;  // [R20]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg  <= FPD_CTRL_RST;
      phase_len <= FPD_PHASE_RST;
      wp_sticky <= 1'b0;
    end
    else
    begin
      ctrl_reg  <= next_ctrl_reg;
      phase_len <= next_phase_len;
      wp_sticky <= next_wp_sticky;
    end
  end

  // read data register
  logic [31:0] next_prdata;
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      if (paddr == FPD_CTRL_ADDR)
        next_prdata = {27'h0, ctrl_reg};
      else if (paddr == FPD_STATUS_ADDR)
        next_prdata = {26'h0, motor_on_5, strobe, pc_active, head_settled,
                       inner_trk, wp_sticky};
      else if (paddr == FPD_PHASE_ADDR)
        next_prdata = {24'h0, phase_len};
    end
    else if (psel && penable)
      next_prdata = prdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
      prdata <= next_prdata;
  end

  // ----------------------------------------
  // data recovery control
  // ----------------------------------------
  assign recovery_on = !ctl.write_gate && !recovery_enable_fault;  // [R1]
  assign rclk_div    = ctrl_reg[FPD_C_DOUBLE_DENSITY_ENABLE] ? 5'd16 : 5'd8;       // [R2]

  // ----------------------------------------
  // write precompensation
  // ----------------------------------------
  // inner-track level: track flag or software request (active low)
  assign inner_trk = ctl.inner_track_flag || !ctrl_reg[FPD_C_PRECOMP];  // [R8] [R9]
  // precomp only in double density on inner tracks
  assign pc_active = ctrl_reg[FPD_C_DOUBLE_DENSITY_ENABLE] && inner_trk;  // [R3] [R7]

  fpd_pc_e     pc_st;
  fpd_pc_e     next_pc_st;
  logic [1:0]  phase;
  logic [1:0]  next_phase;
  logic [7:0]  pcnt;
  logic [7:0]  next_pcnt;
  logic        next_strobe;
  logic        next_wpo;
  logic [1:0]  out_phase;

  // which phase carries the bit out
  always_comb
  begin
    if (!pc_active)
      out_phase = 2'd1;
    else if (ctl.early)
      out_phase = 2'd0;  // [R4]
    else if (ctl.late)
      out_phase = 2'd2;  // [R4]
    else
      out_phase = 2'd1;  // [R4]
  end

  // ripple through four phases, each phase_len cycles long
  always_comb
  begin
    next_pc_st  = pc_st;
    next_phase  = phase;
    next_pcnt   = pcnt;
    next_strobe = strobe;
    next_wpo    = 1'b0;
    case (pc_st)
      FPD_IDLE:
      begin
        if (ctl.write_bit && ctl.write_gate)
        begin
          next_strobe = 1'b1;  // [R5]
          next_pc_st  = FPD_RIPPLE;
          next_phase  = 2'd0;
          next_pcnt   = 8'h00;
        end
      end
      FPD_RIPPLE:
      begin
        if (pcnt == 8'h00 && phase == out_phase)
          next_wpo = 1'b1;  // [R22]
        if (pcnt == phase_len - 8'h01)
        begin
          next_pcnt = 8'h00;
          if (phase == 2'd3)
          begin
            next_strobe = 1'b0;  // [R6]
            next_pc_st  = FPD_IDLE;
          end
          else
            next_phase = phase + 2'd1;
        end
        else
          next_pcnt = pcnt + 8'h01;  // [R23]
      end
      default:
        next_pc_st = FPD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_st           <= FPD_IDLE;
      phase           <= 2'd0;
      pcnt            <= 8'h00;
      strobe          <= 1'b0;
      write_pulse_out <= 1'b0;
    end
    else
    begin
      pc_st           <= next_pc_st;
      phase           <= next_phase;
      pcnt            <= next_pcnt;
      strobe          <= next_strobe;
      write_pulse_out <= next_wpo;
    end
  end

  // ----------------------------------------
  // head load settle and motor delay
  // ----------------------------------------
  logic [31:0] settle_cnt;
  logic [31:0] next_settle_cnt;
  logic [63:0] motor_cnt;
  logic [63:0] next_motor_cnt;
  logic        hl_q;

  always_comb
  begin
    next_settle_cnt = settle_cnt;
    if (ctl.head_load_cmd && !hl_q)
      next_settle_cnt = 32'(SETTLE_CYC);  // [R10]
    else if (!ctl.head_load_cmd)
      next_settle_cnt = 32'(SETTLE_CYC);
    else if (settle_cnt != 32'h0)
      next_settle_cnt = settle_cnt - 32'h1;
    next_motor_cnt = motor_cnt;
    if (ctl.access)
      next_motor_cnt = MOTOR_CYC;  // [R16]
    else if (motor_cnt != 64'h0)
      next_motor_cnt = motor_cnt - 64'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle_cnt <= 32'(SETTLE_CYC);
      motor_cnt  <= 64'h0;
      hl_q       <= 1'b0;
    end
    else
    begin
      settle_cnt <= next_settle_cnt;
      motor_cnt  <= next_motor_cnt;
      hl_q       <= ctl.head_load_cmd;
    end
  end

  // settled drops in the same cycle as the head-load command
  assign head_settled = ctl.head_load_cmd && hl_q && (settle_cnt == 32'h0);  // [R10]
  assign motor_on_5   = !ctrl_reg[FPD_C_EIGHT]
                        && (ctl.access || motor_cnt != 64'h0);  // [R16]

  // ----------------------------------------
  // controller clock 1 or 2 MHz
  // ----------------------------------------
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic       next_ctrl_clk;
  logic       fast;
  logic [7:0] half;

  assign fast = ctrl_reg[FPD_C_EIGHT]                               // [R11]
                || (ctrl_reg[FPD_C_QSEEK] && ctl.seeking);        // [R12]
  assign half = fast ? 8'(FPD_DIV_2MHZ) : 8'(FPD_DIV_1MHZ);

  always_comb
  begin
    next_div_cnt  = div_cnt + 8'h01;
    next_ctrl_clk = ctrl_clk;
    if (div_cnt >= half - 8'h01)
    begin
      next_div_cnt  = 8'h00;
      next_ctrl_clk = !ctrl_clk;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt  <= 8'h00;
      ctrl_clk <= 1'b0;
    end
    else
    begin
      div_cnt  <= next_div_cnt;
      ctrl_clk <= next_ctrl_clk;
    end
  end

  // ----------------------------------------
  // drive cable steering
  // ----------------------------------------
  always_comb
  begin
    if (ctrl_reg[FPD_C_EIGHT])
    begin
      drv_in                   = drv8;  // [R14]
      drv_in.ready             = !drv8.ready;
      drv_in.double_sided_flag = !drv8.double_sided_flag;
    end
    else
      drv_in = drv5;  // [R15]
  end

  assign head_load_8_n  = !(ctl.head_load_cmd && ctrl_reg[FPD_C_EIGHT]);  // [R13]
  assign head_load_5    = ctl.head_load_cmd && !ctrl_reg[FPD_C_EIGHT];
  assign step_out       = ctl.step;     // [R19]
  assign dir_out        = ctl.step_in;  // [R17]
  assign surface_select = ctl.side;     // [R18]
  assign write_refused  = ctl.write_cmd && drv_in.write_protected_in;  // [R20]
  assign bus_ready      = !(ctrl_reg[FPD_C_WAIT_INSERT_ENABLE] && ctl.data_reg_acc
                            && !ctl.xfer_req);  // [R21]

endmodule : fpd_top

/* File: tb/fpd_props.sv */
// checker: port-level properties of the floppy precomp block
`timescale 1ns/1ps

module fpd_props
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // watched ports
  input wire fpd_pkg::fpd_ctl_s ctl,
  input wire logic              recovery_enable_fault,
  input wire logic              recovery_on,
  input wire logic              head_settled,
  input wire logic              write_refused,
  input wire logic              write_pulse_out,
  input wire logic              head_load_8_n,
  input wire logic              head_load_5,
  input wire logic              step_out,
  input wire logic              dir_out,
  input wire logic              surface_select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // recovery, head load and cable levels
  chk_rec_gate: assert property (
    recovery_on == !(ctl.write_gate || recovery_enable_fault)) else $error("recovery gate");
  chk_hl_inv: assert property (
    head_load_8_n == !(ctl.head_load_cmd && !head_load_5)) else $error("head load polarity");
  chk_dir_level: assert property (
    dir_out == ctl.step_in) else $error("direction level");
  chk_side_level: assert property (
    surface_select == ctl.side) else $error("surface level");
  chk_step_pass: assert property (
    step_out == ctl.step) else $error("step pulse");
  // settle timer and write path
  chk_settle_hold: assert property (
    $rose(ctl.head_load_cmd) |-> !head_settled [*8]) else $error("settle too soon");
  chk_settle_drop: assert property (
    !ctl.head_load_cmd |-> !head_settled) else $error("settled without load");
  chk_refuse_cause: assert property (
    write_refused |-> ctl.write_cmd) else $error("refusal without command");
  chk_wpo_single: assert property (
    write_pulse_out |=> !write_pulse_out) else $error("write pulse too long");
  // main scenarios reached
  cov_settled: cover property ($rose(head_settled));
  cov_write: cover property (write_pulse_out);
  cov_refused: cover property (write_refused);
endmodule : fpd_props

bind fpd_top fpd_props u_props (.pclk, .presetn, .ctl, .recovery_enable_fault,
  .recovery_on, .head_settled, .write_refused, .write_pulse_out, .head_load_8_n, .head_load_5,
  .step_out, .dir_out, .surface_select);

/* File: tb/fpd_drive_model.sv */
// drive model: status lines of both cables and a head position counter
`timescale 1ns/1ps

module fpd_drive_model
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // from the block
  input  wire logic         step_out,
  input  wire logic         dir_out,
  input  wire logic [4:0]   st,
  // to the block
  output fpd_pkg::fpd_drv_s drv8,
  output fpd_pkg::fpd_drv_s drv5,
  output logic [6:0]        track
);
  logic [6:0] next_track;

  // one track per step pulse, inward when direction is high
  always_comb
  begin
    next_track = track;
    if (step_out)
      next_track = dir_out ? track + 7'h01 : track - 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      track <= 7'h00;
    else
      track <= next_track;
  end

  // raw cable levels; the small cable inverts the st lines, track0 is the same on both
  assign drv8 = {st[4:1], track == 7'h00};
  assign drv5 = {~st[4:1], track == 7'h00};
endmodule : fpd_drive_model

/* File: tb/tb_top.sv */
// testbench: apb, precomp timing, clocks, settle, motor and cable checks
`timescale 1ns/1ps

module tb_top;
  import fpd_pkg::*;
  localparam int SETTLE = 20;
  localparam int MOTOR  = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r;
  fpd_ctl_s    ctl;
  fpd_drv_s    drv8, drv5, drv_in;
  logic        rfault, rec_on, ctrl_clk, settled, refused, bus_ready;
  logic        wpo, hl8_n, hl5, motor, step, dir, side;
  logic [4:0]  rdiv, st;
  logic [6:0]  track;
  int          err_total, samples_checked, cyc, pulses, pcyc, c1;
  logic [7:0]  pc_ctrl [6] = '{8'h12, 8'h12, 8'h12, 8'h12, 8'h10, 8'h02};
  logic [2:0]  pc_sel  [6] = '{3'h6, 3'h4, 3'h5, 3'h1, 3'h1, 3'h5};
  int          pc_exp  [6] = '{2, 4, 6, 4, 6, 4};
  logic [7:0]  cc_ctrl [4] = '{8'h02, 8'h03, 8'h06, 8'h06};
  int          cc_exp  [4] = '{100, 50, 50, 100};

  fpd_top #(.SETTLE_CYC(SETTLE), .MOTOR_CYC(MOTOR)) uut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctl,
    .recovery_enable_fault(rfault), .raw_flux_stream(st[0]), .recovery_on(rec_on),
    .rclk_div(rdiv), .ctrl_clk, .head_settled(settled), .write_refused(refused),
    .bus_ready, .drv8, .drv5, .drv_in, .write_pulse_out(wpo), .head_load_8_n(hl8_n),
    .head_load_5(hl5), .motor_on_5(motor), .step_out(step), .dir_out(dir),
    .surface_select(side));
  fpd_drive_model dm (.pclk, .presetn, .step_out(step), .dir_out(dir), .st, .drv8,
    .drv5, .track);

  // clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // cycle count, write pulse log and hang limit
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (wpo === 1'b1)
    begin
      pulses++;
      pcyc = cyc;
    end
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // selected cable as the block should pass it
  function automatic logic [4:0] exp_drv(input logic eight);
    return eight ? 5'({drv8} ^ 5'h18) : {drv5};
  endfunction : exp_drv

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ctl = '0;
    rfault = 1'b0;
    st = 5'h1f;
    r = $urandom(32'h1c63d6d1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, FPD_CTRL_ADDR, 32'h0);
    chk("ctrl reset", rd, 32'h2);
    apb(1'b0, FPD_PHASE_ADDR, 32'h0);
    chk("phase reset", rd, 32'hc);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", se, 1'b1);
    apb(1'b1, FPD_PHASE_ADDR, 32'h2);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, FPD_CTRL_ADDR, {24'h0, pc_ctrl[i]});
      {ctl.inner_track_flag, ctl.early, ctl.late} <= pc_sel[i];
      ctl.write_gate <= 1'b1;
      ctl.write_bit <= 1'b1;
      pulses = 0;
      @(posedge pclk);
      c1 = cyc;
      ctl.write_bit <= 1'b0;
      @(posedge pclk);
      ctl.write_bit <= 1'b1;
      @(posedge pclk);
      ctl.write_bit <= 1'b0;
      repeat (14) @(posedge pclk);
      chk("pc delay", pcyc - c1, pc_exp[i]);
      chk("pc pulses", pulses, 1);
    end
    $display("test precomp done");
    for (int i = 0; i < 40; i++)
    begin
      r = $urandom;
      apb(1'b1, FPD_CTRL_ADDR, {27'h0, r[4:0]});
      st <= r[12:8];
      rfault <= r[13];
      ctl.write_gate <= r[14];
      ctl.step_in <= r[15];
      ctl.side <= r[16];
      ctl.data_reg_acc <= r[17];
      ctl.xfer_req <= r[18];
      ctl.head_load_cmd <= r[19];
      @(posedge pclk);
      #1;
      chk("recovery", rec_on, !(r[14] | r[13]));
      chk("rclk div", rdiv, r[4] ? 5'h10 : 5'h08);
      chk("cable in", drv_in, exp_drv(r[0]));
      chk("dir", dir, r[15]);
      chk("side", side, r[16]);
      chk("bus ready", bus_ready, !(r[3] & r[17] & !r[18]));
      chk("head load", {hl8_n, hl5}, {!(r[19] & r[0]), r[19] & !r[0]});
      @(posedge pclk);
    end
    ctl.head_load_cmd <= 1'b0;
    $display("test random levels done");
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, FPD_CTRL_ADDR, {24'h0, cc_ctrl[i]});
      ctl.seeking <= (i == 2);
      @(posedge ctrl_clk);
      @(posedge ctrl_clk);
      #1 c1 = cyc;
      @(posedge ctrl_clk);
      #1;
      chk("ctrl clk", cyc - c1, cc_exp[i]);
      @(posedge pclk);
    end
    $display("test controller clock done");
    apb(1'b1, FPD_CTRL_ADDR, 32'h3);
    ctl.head_load_cmd <= 1'b1;
    repeat (SETTLE) @(posedge pclk);
    #1;
    chk("settle early", settled, 1'b0);
    chk("head load 8in", hl8_n, 1'b0);
    repeat (2) @(posedge pclk);
    #1;
    chk("settle done", settled, 1'b1);
    @(posedge pclk);
    ctl.head_load_cmd <= 1'b0;
    apb(1'b1, FPD_CTRL_ADDR, 32'h2);
    for (int j = 0; j < 2; j++)
    begin
      st <= j ? 5'h00 : 5'h1f;
      ctl.write_cmd <= 1'b1;
      #1;
      chk("refused", refused, j[0]);
      @(posedge pclk);
      ctl.write_cmd <= 1'b0;
      apb(1'b0, FPD_STATUS_ADDR, 32'h0);
      chk("wp status", rd[0], j[0]);
    end
    $display("test settle and protect done");
    ctl.access <= 1'b1;
    repeat (4) @(posedge pclk);
    ctl.access <= 1'b0;
    repeat (MOTOR - 5) @(posedge pclk);
    #1;
    chk("motor hold", motor, 1'b1);
    repeat (8) @(posedge pclk);
    #1;
    chk("motor off", motor, 1'b0);
    @(posedge pclk);
    for (int j = 0; j < 3; j++)
    begin
      ctl.step_in <= (j < 2);
      ctl.step <= 1'b1;
      @(posedge pclk);
      ctl.step <= 1'b0;
      @(posedge pclk);
    end
    chk("track", track, 7'h01);
    $display("test motor and step done");
    summarize();
  end
endmodule : tb_top
